// ### logic/tgsc_pkg.sv
`default_nettype none
package tgsc_pkg;
  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int FIELD_SAMPLE_NS = 1200;
  localparam int FIELD_SAMPLE_CYC = FIELD_SAMPLE_NS / CLK_PERIOD_NS;
  localparam int GATE_MAX_NS = 100;
  localparam int GATE_MAX_CYC = GATE_MAX_NS / CLK_PERIOD_NS;
  localparam real MON_FIELD_US = 16683.4;
  localparam real REC_FRAME_US = 33366.7;
  localparam real LINE_CLK_US = 0.0815;
  // ------------------------------------------------------------
  // Word layout
  // ------------------------------------------------------------
  localparam int WORD_BITS = 72;
  localparam logic [6:0] WORD_BITS_C = 7'h48;
  localparam logic [7:0] CHIP_SELECT = 8'h81;
  localparam int CHIP_LSB = 0;
  localparam int CAT_LSB = 8;
  localparam int SMD_LSB = 16;
  localparam int FRM_LSB = 18;
  localparam int HD_LSB = 26;
  localparam int EXPOSURE_PREP_BIT = 48;
  localparam int DRIVE_BIT = 51;
  localparam int SSG_BIT = 52;
  localparam int WEN_BIT = 53;
  localparam int CLP_BIT = 54;
  localparam int ID_BIT = 55;
  localparam int HMCK_BIT = 56;
  localparam int TMCK_BIT = 57;
  localparam int PIXEL_PHASE_POLARITY_BIT = 58;
  localparam int SP_CLOCK_POLARITY_BIT = 59;
  localparam int GATE_LSB = 60;
  localparam int PWR_LSB = 62;
  localparam int SUM_LSB = 64;
  localparam int PAYLOAD_BITS = 56;
  localparam logic [9:0] HD_SINGLE_LINE = 10'h107;
  localparam logic [7:0] FRM_RESET = 8'h00;
  localparam logic [9:0] HD_RESET = 10'h000;
  localparam logic [8:0] LOCK_RESET = 9'h000;
  localparam logic [6:0] PIN_IDLE = 7'h13;

  typedef enum logic [1:0] {TGSC_SHUT_STOP, TGSC_SHUT_SPEED, TGSC_SHUT_GATED} tgsc_shut_t;
  typedef enum logic [1:0] {TGSC_PWR_NORMAL, TGSC_PWR_SLEEP, TGSC_PWR_STANDBY} tgsc_pwr_t;

  typedef struct packed {
    logic [1:0] shutter_mode;
    logic [7:0] shutter_frames;
    logic [9:0] shutter_lines;
    logic exposure_prep;
    logic drive_mode_select;
    logic write_strobe_off;
    logic black_clamp_on;
    logic line_parity_on;
    logic pixel_phase_on;
    logic sp_clock_off;
    logic pixel_phase_polarity;
    logic sp_clock_polarity;
    logic [1:0] gate_group_select;
  } tgsc_ctrl_t;

  typedef struct packed {
    logic horiz_clock_a;
    logic horiz_clock_b;
    logic reset_gate_pulse;
    logic vert_clock_a;
    logic vert_clock_b;
    logic vert_clock_c;
    logic shutter_pulse;
    logic readout_pulse_a;
    logic readout_pulse_b;
  } tgsc_sensor_t;

  typedef struct packed {
    logic precharge_hold;
    logic data_level_hold;
    logic adc_phase_hold;
    logic blank_clean_pulse;
    logic black_clamp_pulse;
    logic dummy_clamp_pulse;
    logic adc_clock;
  } tgsc_shgrp_t;

  typedef struct packed {
    logic hsync_out;
    logic vsync_out;
    logic write_strobe;
    logic line_parity_pulse;
    logic pixel_phase_pulse;
    logic sp_clock_out;
    logic proc_clock;
  } tgsc_misc_t;

  typedef struct packed {
    tgsc_sensor_t sensor;
    tgsc_shgrp_t shgrp;
    tgsc_misc_t misc;
  } tgsc_pulses_t;
endpackage
`default_nettype wire

// ### logic/tgsc_serial_control.sv
`default_nettype none
// Behaviour
// - Sample hsync a fixed delay after vsync falls; low odd, high even.
// - Gate pin falling forces selected output groups low within 100 ns.
// - Accept a word only when its select byte is 10000001.
// - Checksum pin low: check byte must hold; high: check byte ignored.
// - Nine bytes including check byte sum to zero modulo 256.
// - Category bit 8 routes payload to control or adjustment register.
// - Shutter mode: bit16 zero stopped, 01 speed, 11 readout-gated.
// - Speed mode uses frame and line counts; other modes ignore them.
// - Stopped shutter exposes one field (monitoring) or one frame (recording).
// - Frame count of one or more locks out new words until exposure ends.
// - Frame count unit is a field in monitoring, a frame in recording.
// - Exposure is frames times field (monitoring) or frame (recording) time plus line term times 0.0815 us.
// - Frames 00h, lines 107h: one shutter pulse odd, two even.
// - Readout-gated mode extends exposure while readout pulses are held off.
// - Bit 51 selects monitoring or recording drive, locked to input sync.
// - Shutter pulse always follows the first readout pulse line.
// - Gate-select field picks neither, sensor, hold/converter or both groups.
// - Sensor group and hold/converter group membership as listed.
// - Power field: normal, sleep, standby; acts at strobe rising edge.
// - Sleep and standby hold outputs low; standby also sync and clocks.
// - Bits 52, 54, 55, 56 enable sync, clamp, parity, pixel phase.
// - Bits 53 and 57 disable write strobe and processor clock.
// - Bits 58, 59 set pixel phase and processor clock polarity.
// - Control data takes effect at hsync fall with strobe high; sync, power, adjustment data at strobe.
module tgsc_serial_control (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Serial port
  input wire logic serial_in,
  input wire logic serial_clk,
  input wire logic serial_strobe,
  input wire logic checksum_enable_pin,
  // Sync and gate pins
  input wire logic hsync_in,
  input wire logic vsync_in,
  input wire logic pulse_gate_pin,
  // Raw waveforms from the pulse generator
  input wire tgsc_pkg::tgsc_pulses_t raw_pulses,
  // Gated outputs
  output var tgsc_pkg::tgsc_pulses_t out_pulses,
  // State to the pulse generator
  output var tgsc_pkg::tgsc_ctrl_t ctrl,
  output logic [tgsc_pkg::PAYLOAD_BITS-1:0] adjust_data,
  output logic internal_sync_on,
  output logic [1:0] power_state_select,
  output logic field_even,
  output logic shutter_locked,
  output logic [1:0] shutter_pulses_per_field,
  output logic [7:0] held_readout_fields
);
  import tgsc_pkg::*;

  function automatic logic [7:0] byte_sum(input logic [WORD_BITS-1:0] w);
    logic [7:0] s;
    s = 8'h00;
    for (int i = 0; i < WORD_BITS / 8; i++) begin
      s = s + w[i*8 +: 8];
    end
    return s;
  endfunction

  function automatic logic fell(input logic [1:0] h);
    return h[1] & ~h[0];
  endfunction

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  logic [6:0] meta_reg;
  logic [6:0] sync_reg;
  logic [1:0] sclk_h_reg, strobe_h_reg, hs_h_reg, vs_h_reg;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      meta_reg <= PIN_IDLE;
      sync_reg <= PIN_IDLE;
    end else begin
      meta_reg <= {serial_in, serial_clk, serial_strobe, checksum_enable_pin, hsync_in, vsync_in, pulse_gate_pin};
      sync_reg <= meta_reg;
    end
  end

  logic s_data, s_clk, s_strobe, s_cksum_off, s_hs, s_vs, s_gate;
  assign {s_data, s_clk, s_strobe, s_cksum_off, s_hs, s_vs, s_gate} = sync_reg;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sclk_h_reg <= 2'h0;
      strobe_h_reg <= {2{PIN_IDLE[4]}};
      hs_h_reg <= 2'h0;
      vs_h_reg <= {2{PIN_IDLE[1]}};
    end else begin
      sclk_h_reg <= {sclk_h_reg[0], s_clk};
      strobe_h_reg <= {strobe_h_reg[0], s_strobe};
      hs_h_reg <= {hs_h_reg[0], s_hs};
      vs_h_reg <= {vs_h_reg[0], s_vs};
    end
  end

  logic sclk_rise, strobe_rise, hs_fall, vs_fall;
  assign sclk_rise = sclk_h_reg[0] & ~sclk_h_reg[1];
  assign strobe_rise = strobe_h_reg[0] & ~strobe_h_reg[1];
  assign hs_fall = fell(hs_h_reg);
  assign vs_fall = fell(vs_h_reg);

  // ------------------------------------------------------------
  // Shift register and word check
  // ------------------------------------------------------------
  logic [WORD_BITS-1:0] shift_reg;
  logic [6:0] count_reg;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      shift_reg <= '0;
      count_reg <= 7'h00;
    end else if (strobe_rise) begin
      count_reg <= 7'h00;
    end else if (sclk_rise && !s_strobe) begin
      shift_reg <= {s_data, shift_reg[WORD_BITS-1:1]};
      if (count_reg != 7'h7f) begin
        count_reg <= count_reg + 7'h01;
      end
    end
  end

  logic word_ok, accept, to_ctrl, to_adjust;
  assign word_ok = (count_reg == WORD_BITS_C)
    && (shift_reg[CHIP_LSB +: 8] == CHIP_SELECT)
    && (s_cksum_off || byte_sum(shift_reg) == 8'h00)
    && (shift_reg[CAT_LSB+1 +: 7] == 7'h00);
  assign accept = strobe_rise && word_ok && !shutter_locked;
  assign to_ctrl = accept && !shift_reg[CAT_LSB];
  assign to_adjust = accept && shift_reg[CAT_LSB];

  // ------------------------------------------------------------
  // Control registers
  // ------------------------------------------------------------
  tgsc_ctrl_t ctrl_reg, ctrl_next, pend_reg;
  logic pend_valid_reg;
  logic [PAYLOAD_BITS-1:0] adjust_reg;
  logic ssg_reg;
  logic [1:0] pwr_reg;

  always_comb begin
    ctrl_next.shutter_mode = shift_reg[SMD_LSB +: 2];
    ctrl_next.shutter_frames = shift_reg[FRM_LSB +: 8];
    ctrl_next.shutter_lines = shift_reg[HD_LSB +: 10];
    ctrl_next.exposure_prep = shift_reg[EXPOSURE_PREP_BIT];
    ctrl_next.drive_mode_select = shift_reg[DRIVE_BIT];
    ctrl_next.write_strobe_off = shift_reg[WEN_BIT];
    ctrl_next.black_clamp_on = shift_reg[CLP_BIT];
    ctrl_next.line_parity_on = shift_reg[ID_BIT];
    ctrl_next.pixel_phase_on = shift_reg[HMCK_BIT];
    ctrl_next.sp_clock_off = shift_reg[TMCK_BIT];
    ctrl_next.pixel_phase_polarity = shift_reg[PIXEL_PHASE_POLARITY_BIT];
    ctrl_next.sp_clock_polarity = shift_reg[SP_CLOCK_POLARITY_BIT];
    ctrl_next.gate_group_select = shift_reg[GATE_LSB +: 2];
  end

  // Immediate fields at strobe rise
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ssg_reg <= 1'b0;
      pwr_reg <= 2'h0;
    end else if (to_ctrl) begin
      ssg_reg <= shift_reg[SSG_BIT];
      pwr_reg <= shift_reg[PWR_LSB +: 2];
    end
  end

  // Remaining fields wait for hsync fall while strobe stays high
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pend_reg <= '0;
      pend_valid_reg <= 1'b0;
      ctrl_reg <= '0;
    end else if (to_ctrl) begin
      pend_reg <= ctrl_next;
      pend_valid_reg <= 1'b1;
    end else if (pend_valid_reg && hs_fall && s_strobe) begin
      ctrl_reg <= pend_reg;
      pend_valid_reg <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      adjust_reg <= '0;
    end else if (to_adjust) begin
      adjust_reg <= shift_reg[WORD_BITS-1:SMD_LSB];
    end
  end

  tgsc_shut_t shut_mode;
  tgsc_pwr_t pwr_mode;
  always_comb begin
    unique case ({ctrl_reg.shutter_mode[1], ctrl_reg.shutter_mode[0]})
      2'b01: shut_mode = TGSC_SHUT_SPEED;
      2'b11: shut_mode = TGSC_SHUT_GATED;
      default: shut_mode = TGSC_SHUT_STOP;
    endcase
    unique case (pwr_reg)
      2'b01: pwr_mode = TGSC_PWR_SLEEP;
      2'b11: pwr_mode = TGSC_PWR_STANDBY;
      default: pwr_mode = TGSC_PWR_NORMAL;
    endcase
  end

  // ------------------------------------------------------------
  // Field identification
  // ------------------------------------------------------------
  logic [7:0] fid_cnt_reg;
  logic field_even_reg;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      fid_cnt_reg <= 8'h00;
      field_even_reg <= 1'b0;
    end else if (vs_fall) begin
      fid_cnt_reg <= 8'(FIELD_SAMPLE_CYC);
    end else if (fid_cnt_reg != 8'h00) begin
      fid_cnt_reg <= fid_cnt_reg - 8'h01;
      if (fid_cnt_reg == 8'h01) begin
        field_even_reg <= s_hs;
      end
    end
  end

  // ------------------------------------------------------------
  // Shutter exposure
  // ------------------------------------------------------------
  logic [8:0] lock_cnt_reg;
  logic [7:0] held_reg;
  logic ro_seen_reg, force_arm_reg, force_win_reg, ro_prev_reg;
  logic ro_rise;
  assign ro_rise = raw_pulses.sensor.readout_pulse_a & ~ro_prev_reg;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      lock_cnt_reg <= LOCK_RESET;
    end else if (to_ctrl && ctrl_next.shutter_mode == 2'b01 && ctrl_next.shutter_frames != FRM_RESET) begin
      // Frame unit is one field in monitoring, two in recording
      lock_cnt_reg <= ctrl_next.drive_mode_select ? {ctrl_next.shutter_frames, 1'b0}
                                                  : {1'b0, ctrl_next.shutter_frames};
    end else if (vs_fall && lock_cnt_reg != LOCK_RESET) begin
      lock_cnt_reg <= lock_cnt_reg - 9'h001;
    end
  end

  // Readout-gated mode: fields with readout held off extend exposure
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      held_reg <= 8'h00;
      ro_prev_reg <= 1'b0;
      ro_seen_reg <= 1'b0;
      force_arm_reg <= 1'b0;
      force_win_reg <= 1'b0;
    end else begin
      ro_prev_reg <= raw_pulses.sensor.readout_pulse_a;
      if (ro_rise) begin
        held_reg <= 8'h00;
      end else if (vs_fall && shut_mode == TGSC_SHUT_GATED && held_reg != 8'hff) begin
        held_reg <= held_reg + 8'h01;
      end
      if (vs_fall) begin
        ro_seen_reg <= 1'b0;
      end else if (ro_rise && !ro_seen_reg) begin
        ro_seen_reg <= 1'b1;
        force_arm_reg <= 1'b1;
      end
      if (hs_fall) begin
        force_win_reg <= force_arm_reg;
        if (force_arm_reg) begin
          force_arm_reg <= 1'b0;
        end
      end
    end
  end

  logic shutter_gate;
  assign shutter_gate = (shut_mode != TGSC_SHUT_STOP) || force_win_reg;

  // ------------------------------------------------------------
  // Output gating
  // ------------------------------------------------------------
  tgsc_pulses_t out_reg;
  logic kill_sensor, kill_shgrp, standby;
  assign standby = pwr_mode == TGSC_PWR_STANDBY;
  assign kill_sensor = (!s_gate && ctrl_reg.gate_group_select[0]) || pwr_mode != TGSC_PWR_NORMAL;
  assign kill_shgrp = (!s_gate && ctrl_reg.gate_group_select[1]) || pwr_mode != TGSC_PWR_NORMAL;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      out_reg <= '0;
    end else begin
      out_reg.sensor <= kill_sensor ? '0 : raw_pulses.sensor;
      out_reg.sensor.shutter_pulse <= !kill_sensor && raw_pulses.sensor.shutter_pulse && shutter_gate;
      out_reg.shgrp <= kill_shgrp ? '0 : raw_pulses.shgrp;
      out_reg.shgrp.black_clamp_pulse <= !kill_shgrp && raw_pulses.shgrp.black_clamp_pulse
                                         && ctrl_reg.black_clamp_on;
      out_reg.misc.hsync_out <= !standby && raw_pulses.misc.hsync_out;
      out_reg.misc.vsync_out <= !standby && raw_pulses.misc.vsync_out;
      out_reg.misc.proc_clock <= !standby && raw_pulses.misc.proc_clock;
      out_reg.misc.sp_clock_out <= !standby && !ctrl_reg.sp_clock_off
                                   && (raw_pulses.misc.sp_clock_out ^ !ctrl_reg.sp_clock_polarity);
      out_reg.misc.write_strobe <= pwr_mode == TGSC_PWR_NORMAL && !ctrl_reg.write_strobe_off
                                   && raw_pulses.misc.write_strobe;
      out_reg.misc.line_parity_pulse <= pwr_mode == TGSC_PWR_NORMAL && ctrl_reg.line_parity_on
                                        && raw_pulses.misc.line_parity_pulse;
      out_reg.misc.pixel_phase_pulse <= pwr_mode == TGSC_PWR_NORMAL && ctrl_reg.pixel_phase_on
                                        && (raw_pulses.misc.pixel_phase_pulse ^ ctrl_reg.pixel_phase_polarity);
    end
  end

  // Frames 00h with line count 107h: one pulse odd, two even
  assign shutter_pulses_per_field = (shut_mode == TGSC_SHUT_SPEED && ctrl_reg.shutter_frames == FRM_RESET
                                     && ctrl_reg.shutter_lines == HD_SINGLE_LINE)
                                    ? (field_even_reg ? 2'h2 : 2'h1) : 2'h0;

  assign out_pulses = out_reg;
  assign ctrl = ctrl_reg;
  assign adjust_data = adjust_reg;
  assign internal_sync_on = ssg_reg;
  assign power_state_select = pwr_reg;
  assign field_even = field_even_reg;
  assign shutter_locked = lock_cnt_reg != LOCK_RESET;
  assign held_readout_fields = held_reg;
endmodule
`default_nettype wire

// ### sim/tgsc_serial_control_properties.sv
`default_nettype none
module tgsc_serial_control_checker (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Pins
  input wire logic serial_strobe,
  input wire logic pulse_gate_pin,
  // Outputs watched
  input wire tgsc_pkg::tgsc_pulses_t out_pulses,
  input wire tgsc_pkg::tgsc_ctrl_t ctrl,
  input wire logic [tgsc_pkg::PAYLOAD_BITS-1:0] adjust_data,
  input wire logic [1:0] power_state_select,
  input wire logic field_even,
  input wire logic shutter_locked,
  input wire logic [1:0] shutter_pulses_per_field
);
  timeunit 1ns;
  timeprecision 1ns;
  import tgsc_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  chk_reset_clear: assert property (disable iff (1'b0) !rst_n
    |=> ctrl == '0 && power_state_select == 2'h0)
    else $error("control not cleared by reset");
  chk_gate_sensor: assert property (!pulse_gate_pin [*8] ##0 ctrl.gate_group_select[0]
    && $past(ctrl.gate_group_select[0]) |-> out_pulses.sensor == '0)
    else $error("sensor group not held low by gate");
  chk_gate_hold: assert property (!pulse_gate_pin [*8] ##0 ctrl.gate_group_select[1]
    && $past(ctrl.gate_group_select[1]) |-> out_pulses.shgrp == '0)
    else $error("hold group not held low by gate");
  chk_low_power: assert property (power_state_select[0] && $past(power_state_select[0])
    |-> out_pulses.sensor == '0 && out_pulses.shgrp == '0)
    else $error("pulses active in low power");
  chk_standby_sync: assert property (power_state_select == 2'h3 && $past(power_state_select) == 2'h3
    |-> {out_pulses.misc.hsync_out, out_pulses.misc.vsync_out, out_pulses.misc.proc_clock} == 3'h0)
    else $error("sync or clocks active in standby");
  chk_ctrl_quiet: assert property (!serial_strobe [*8] |-> $stable(ctrl))
    else $error("control changed with strobe low");
  chk_shot_pair: assert property (ctrl.shutter_mode == 2'h1 && ctrl.shutter_frames == 8'h00
    && ctrl.shutter_lines == 10'h107 |-> shutter_pulses_per_field == (field_even ? 2'h2 : 2'h1))
    else $error("wrong shutter pulse count per field");
  chk_shot_none: assert property (ctrl.shutter_lines != 10'h107 |-> shutter_pulses_per_field == 2'h0)
    else $error("shutter pulse count without single line setting");
  chk_wen_off: assert property ($past(ctrl.write_strobe_off) |-> !out_pulses.misc.write_strobe)
    else $error("write strobe active while disabled");
  chk_lock_hold: assert property (shutter_locked && $past(shutter_locked)
    |-> $stable(adjust_data) && $stable(power_state_select))
    else $error("word loaded during exposure lockout");
  cover property (shutter_locked);
  cover property (field_even);
  cover property (power_state_select == 2'h3);
  cover property (!pulse_gate_pin && ctrl.gate_group_select == 2'h3);
endmodule

bind tgsc_serial_control tgsc_serial_control_checker u_chk (.clock, .rst_n, .serial_strobe, .pulse_gate_pin,
  .out_pulses, .ctrl, .adjust_data, .power_state_select, .field_even, .shutter_locked, .shutter_pulses_per_field);
`default_nettype wire

// ### sim/tgsc_host_model.sv
`default_nettype none
module tgsc_host_model (
  // Serial port pins
  output var logic serial_in,
  output var logic serial_clk,
  output var logic serial_strobe
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    serial_in = 1'b0;
    serial_clk = 1'b0;
    serial_strobe = 1'b1;
  end
  // ------------------------------------------------------------
  // Word transfer, clock idles low between words
  // ------------------------------------------------------------
  task automatic send(input logic [71:0] w, input int n, input bit bad);
    logic [7:0] s;
    s = 8'h00;
    for (int k = 0; k < 8; k++) s = s + w[8*k +: 8];
    w[71:64] = bad ? ~s : -s;
    #10 serial_strobe = 1'b0;
    for (int i = 0; i < n; i++) begin
      serial_in = w[i % 72];
      #40 serial_clk = 1'b1;
      #40 serial_clk = 1'b0;
    end
    #40 serial_strobe = 1'b1;
  endtask
endmodule
`default_nettype wire

// ### sim/tb_tgsc_serial_control.sv
`default_nettype none
module tb_tgsc_serial_control;
  timeunit 1ns;
  timeprecision 1ns;
  import tgsc_pkg::*;
  logic clock, rst_n = 1'b0, checksum_enable_pin = 1'b0, hsync_in = 1'b0, vsync_in = 1'b1;
  logic pulse_gate_pin = 1'b1, raw_fix = 1'b0;
  wire logic serial_in, serial_clk, serial_strobe;
  tgsc_pulses_t raw_pulses = '0, out_pulses;
  tgsc_ctrl_t ctrl;
  logic [PAYLOAD_BITS-1:0] adjust_data;
  logic internal_sync_on, field_even, shutter_locked;
  logic [7:0] held_readout_fields;
  logic [1:0] power_state_select, shutter_pulses_per_field;
  logic [15:0] lf = 16'h001f;
  int bad_count = 0, n_compared = 0;

  tgsc_serial_control u_dut (.clock(clock), .rst_n(rst_n), .serial_in(serial_in), .serial_clk(serial_clk),
    .serial_strobe(serial_strobe), .checksum_enable_pin(checksum_enable_pin), .hsync_in(hsync_in),
    .vsync_in(vsync_in), .pulse_gate_pin(pulse_gate_pin), .raw_pulses(raw_pulses), .out_pulses(out_pulses),
    .ctrl(ctrl), .adjust_data(adjust_data), .internal_sync_on(internal_sync_on),
    .power_state_select(power_state_select), .field_even(field_even), .shutter_locked(shutter_locked),
    .shutter_pulses_per_field(shutter_pulses_per_field), .held_readout_fields(held_readout_fields));
  tgsc_host_model u_host (.serial_in(serial_in), .serial_clk(serial_clk), .serial_strobe(serial_strobe));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [15:0] rnd();
    lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
    return lf;
  endfunction
  function automatic logic [71:0] mk(input logic [47:0] p, input logic [7:0] cat);
    return {8'h00, p, cat, CHIP_SELECT};
  endfunction
  function automatic tgsc_ctrl_t exp_ctrl(input logic [47:0] p);
    return {p[1:0], p[9:2], p[19:10], p[32], p[35], p[37], p[38], p[39], p[40], p[41], p[42], p[43], p[45:44]};
  endfunction
  task automatic cmp(input string what, input logic [63:0] exp, input logic [63:0] got);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cmp_flag(input string what, input logic exp, input logic got);
    cmp(what, 64'(exp), 64'(got));
  endtask
  task automatic cmp_pulse(input string what, input logic [15:0] exp, input logic [15:0] got);
    cmp(what, 64'(exp), 64'(got));
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic hs();
    hsync_in = 1'b1;
    cyc(8);
    hsync_in = 1'b0;
    cyc(12);
  endtask
  task automatic put(input logic [47:0] p);
    u_host.send(mk(p, 8'h00), 72, 1'b0);
    cyc(12);
    hs();
  endtask
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  always @(posedge clock) raw_pulses <= #1 raw_fix ? '1 : tgsc_pulses_t'({rnd(), lf[6:0]});

  initial begin
    #400000;
    bad_count++;
    conclude();
  end
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  initial begin
    logic [47:0] p;
    logic [71:0] w;
    tgsc_ctrl_t ec, m;
    cyc(2);
    cmp("ctrl_rst", '0, ctrl);
    cmp("power_rst", 2'h0, power_state_select);
    rst_n = 1'b1;
    cyc(4);
    ec = '0;
    for (int i = 0; i < 6; i++) begin
      p = {rnd(), rnd(), rnd()};
      p[1:0] = (i % 3 == 0) ? 2'b10 : (i % 3 == 1) ? 2'b01 : 2'b11;
      p[9:2] = 8'h00;
      p[19:10] = 10'h107 + 10'(rnd() % 16'h106);
      p[31:20] = 12'h000;
      p[34:33] = 2'b00;
      p[35] = i[0];
      p[32] = ~i[0];
      p[47:46] = (i < 2) ? 2'b00 : (i < 4) ? 2'b01 : 2'b11;
      u_host.send(mk(p, 8'h00), 72, 1'b0);
      cyc(12);
      cmp("power", p[47:46], power_state_select);
      cmp_flag("sync_on", p[36], internal_sync_on);
      cmp("ctrl_held", ec[10:0], ctrl[10:0]);
      hs();
      ec = exp_ctrl(p);
      m = (p[1:0] == 2'b01) ? '1 : 31'h600007ff;
      cmp("ctrl", ec & m, ctrl & m);
    end
    p = '0;
    p[1:0] = 2'b01;
    p[19:10] = 10'h107;
    put(p);
    ec = exp_ctrl(p);
    for (int f = 0; f < 2; f++) begin
      hsync_in = ~f[0];
      vsync_in = 1'b0;
      cyc(75);
      cmp_flag("field_early", f[0], field_even);
      cyc(90);
      cmp_flag("field", !f[0], field_even);
      cmp("shots", f[0] ? 2'h1 : 2'h2, shutter_pulses_per_field);
      vsync_in = 1'b1;
      hsync_in = 1'b0;
      cyc(5);
    end
    p = '0;
    p[36] = 1'b1;
    p[47:46] = 2'b11;
    p[45:44] = 2'b11;
    p[19:10] = HD_SINGLE_LINE;
    for (int k = 0; k < 7; k++) begin
      w = mk(p, 8'h00);
      w[7:0] = (k == 0) ? 8'h80 : (k == 1) ? 8'h01 : 8'h81;
      w[15:8] = (k == 2) ? 8'h02 : 8'h00;
      checksum_enable_pin = (k == 6);
      u_host.send(w, (k == 4) ? 71 : (k == 5) ? 73 : 72, k == 3 || k == 6);
      cyc(12);
      hs();
      cmp("power_refuse", (k == 6) ? 2'h3 : 2'h0, power_state_select);
      cmp("ctrl_refuse", (k == 6) ? exp_ctrl(p) : ec, ctrl);
    end
    checksum_enable_pin = 1'b0;
    ec = exp_ctrl(p);
    p = {rnd(), rnd(), rnd()};
    u_host.send(mk(p, 8'h01), 72, 1'b0);
    cyc(12);
    hs();
    cmp("adjust", p, adjust_data[47:0]);
    cmp("ctrl_adj", ec, ctrl);
    for (int g = 0; g < 4; g++) begin
      p = '0;
      p[1:0] = 2'b01;
      p[19:10] = 10'h200;
      p[38] = 1'b1;
      p[45:44] = g[1:0];
      put(p);
      raw_fix = 1'b1;
      pulse_gate_pin = 1'b0;
      cyc(10);
      cmp_pulse("gated", {g[0] ? 9'h000 : 9'h1ff, g[1] ? 7'h00 : 7'h7f}, {out_pulses.sensor, out_pulses.shgrp});
      pulse_gate_pin = 1'b1;
      raw_fix = 1'b0;
    end
    p[9:2] = 8'h01;
    put(p);
    cmp_flag("locked", 1'b1, shutter_locked);
    p = '0;
    p[19:10] = HD_SINGLE_LINE;
    p[47:46] = 2'b01;
    put(p);
    cmp("power_lock", 2'h0, power_state_select);
    vsync_in = 1'b0;
    cyc(200);
    vsync_in = 1'b1;
    cyc(10);
    cmp_flag("unlocked", 1'b0, shutter_locked);
    put(p);
    cmp("power_after", 2'h1, power_state_select);
    p[1:0] = 2'b11;
    p[47:46] = 2'b00;
    put(p);
    raw_fix = 1'b1;
    for (int v = 0; v < 2; v++) begin
      vsync_in = 1'b0;
      cyc(6);
      vsync_in = 1'b1;
      cyc(6);
    end
    cmp("held", 8'h02, held_readout_fields);
    raw_fix = 1'b0;
    conclude();
  end
endmodule
`default_nettype wire
